// ===== rtl/dtr_relay_ctrl.v
// dual trip relay controller with avalon register slave
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "dtr_defs.vh"
module dtr_relay_ctrl #(
   parameter [27:0] SEC_CYC   = `DTR_SEC_CYC,
   parameter [27:0] HOLD_CYC  = `DTR_HOLD_CYC,
   parameter [27:0] FAST_HALF = `DTR_FAST_HALF,
   parameter [27:0] SLOW_HALF = `DTR_SLOW_HALF
)(
   input  wire        REF_CLK_I,
   input  wire        RST_N_I,
   input  wire [7:0]  AVS_ADDRESS_I,
   input  wire        AVS_READ_I,
   input  wire        AVS_WRITE_I,
   input  wire [3:0]  AVS_BYTEENABLE_I,
   input  wire [31:0] AVS_WRITEDATA_I,
   output reg  [31:0] AVS_READDATA_O,
   output wire        AVS_WAITREQUEST_O,
   input  wire [15:0] PV_I,
   input  wire        SENSOR_BREAK_FLAG_I,
   input  wire        SENSOR_SHORT_FLAG_I,
   input  wire        INPUT_BELOW_RANGE_I,
   input  wire        INPUT_ABOVE_RANGE_I,
   input  wire        INTERNAL_FAULT_I,
   input  wire        KEY_UP_I,
   input  wire        KEY_DOWN_I,
   input  wire        KEY_OK_I,
   output reg  [1:0]  RELAY_O,
   output wire [1:0]  STATUS_FLASH_O,
   output wire [1:0]  RELAY_SYMBOL_O,
   output reg         LED_O,
   output reg         BACKLIGHT_O
);
   // ------------------------
   // reset release
   // ------------------------
   reg         rst_q1;
   reg         rst_n;
   always @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   function [15:0] merge;
      input [15:0] old;
      input [15:0] val;
      input [1:0]  be;
      begin
         merge = {be[1] ? val[15:8] : old[15:8], be[0] ? val[7:0] : old[7:0]};
      end
   endfunction

   // ------------------------
   // state
   // ------------------------
   reg  [15:0] e_mem [0:15];
   reg  [15:0] a_mem [0:15];
   reg         ack;
   reg         cfg_active;
   reg         unlocked;
   reg         lock_en;
   reg  [13:0] pass;
   reg         fast_en;
   reg         fast_free;
   reg         quick;
   reg         test_inv;
   reg  [15:0] quick_sp;
   reg         rsim;
   reg  [1:0]  sim_rel;
   reg         isim;
   reg  [15:0] simval;
   reg  [15:0] span;
   reg  [15:0] offset;
   reg  [5:0]  tout;
   reg  [27:0] okc;
   reg  [27:0] secc;
   reg  [27:0] fcnt;
   reg  [27:0] scnt;
   reg         fast_tog;
   reg         slow_tog;
   reg         up_q;
   reg         dn_q;
   reg         ok_q;
   reg  [31:0] rd;
   integer     i;
   wire        req     = AVS_READ_I | AVS_WRITE_I;
   wire        wr      = AVS_WRITE_I & ack;
   wire        rel_hit = (AVS_ADDRESS_I[7:6] == 2'b00) && (AVS_ADDRESS_I[4:2] < 3'h6);
   wire [3:0]  ridx    = {AVS_ADDRESS_I[5], AVS_ADDRESS_I[4:2]};
   wire [15:0] wd      = AVS_WRITEDATA_I[15:0];
   wire [1:0]  be      = AVS_BYTEENABLE_I[1:0];
   wire        unlk    = ~lock_en | unlocked;
   wire        sec_tick = (secc == SEC_CYC - 28'd1);
   wire        up_e    = KEY_UP_I & ~up_q;
   wire        dn_e    = KEY_DOWN_I & ~dn_q;
   wire        ok_e    = KEY_OK_I & ~ok_q;
   wire        ok_f    = ~KEY_OK_I & ok_q;
   wire        both    = (up_e & KEY_DOWN_I) | (dn_e & KEY_UP_I);
   wire        serr    = SENSOR_BREAK_FLAG_I | SENSOR_SHORT_FLAG_I;
   wire        rerr    = INPUT_BELOW_RANGE_I | INPUT_ABOVE_RANGE_I;
   wire        key_any = up_e | dn_e | ok_e;
   wire        tout_hit = (tout == `DTR_TOUT_S);
   wire        q_ok    = fast_en & (unlk | fast_free)
                         & (a_mem[0][2:0] == `DTR_F_SETPOINT)
                         & (a_mem[8][2:0] == `DTR_F_SETPOINT);
   wire [15:0] pv      = isim ? simval : PV_I + offset;
   wire [1:0]  act_v;
   wire [1:0]  run_v;
   wire [1:0]  con_v;

   assign AVS_WAITREQUEST_O = req & ~ack;
   assign STATUS_FLASH_O    = run_v;
   assign RELAY_SYMBOL_O    = act_v;

   // ------------------------
   // read mux
   // ------------------------
   always @* begin
      rd = 32'h0000_0000;
      if (rel_hit)
         rd = {16'h0000, e_mem[ridx]};
      else begin
         case (AVS_ADDRESS_I)
            `DTR_A_CTRL:   rd = {24'h0, fast_free, fast_en, isim, rsim, 4'h0};
            `DTR_A_PASS:   rd = {15'h0, lock_en, 16'h0};
            `DTR_A_STATUS: rd = {20'h0, rerr, serr, rsim, quick, cfg_active, unlk,
                                 act_v, run_v, RELAY_O};
            `DTR_A_SIMVAL: rd = {16'h0, simval};
            `DTR_A_SPAN:   rd = {16'h0, span};
            `DTR_A_OFFSET: rd = {16'h0, offset};
            `DTR_A_QSP:    rd = {16'h0, quick_sp};
            default:       rd = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------
   // bus, configuration and keys
   // ------------------------
   always @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 16; i = i + 1) begin
            e_mem[i] <= 16'h0000;
            a_mem[i] <= 16'h0000;
         end
         ack <= 1'b0;
         AVS_READDATA_O <= 32'h0000_0000;
         cfg_active <= 1'b0;
         unlocked <= 1'b0;
         lock_en <= 1'b0;
         pass <= 14'h0000;
         fast_en <= 1'b0;
         fast_free <= 1'b0;
         quick <= 1'b0;
         test_inv <= 1'b0;
         quick_sp <= 16'h0000;
         rsim <= 1'b0;
         sim_rel <= 2'h0;
         isim <= 1'b0;
         simval <= 16'h0000;
         span <= `DTR_SPAN_RST;
         offset <= `DTR_OFFSET_RST;
         tout <= 6'h00;
         okc <= 28'h0000000;
         up_q <= 1'b0;
         dn_q <= 1'b0;
         ok_q <= 1'b0;
      end else begin
         ack <= req & ~ack;
         if (req & ~ack)
            AVS_READDATA_O <= rd;
         up_q <= KEY_UP_I;
         dn_q <= KEY_DOWN_I;
         ok_q <= KEY_OK_I;
         if (key_any | wr | rsim | ~(cfg_active | quick))
            tout <= 6'h00;                                            // [RL18]
         else if (sec_tick)
            tout <= tout + 6'h01;
         if (tout_hit) begin                                          // [RL10]
            for (i = 0; i < 16; i = i + 1)
               e_mem[i] <= a_mem[i];
            cfg_active <= 1'b0;
            quick <= 1'b0;
            test_inv <= 1'b0;
            unlocked <= 1'b0;
         end else if (wr) begin
            if (rel_hit && cfg_active && unlk)                        // [RL14]
               e_mem[ridx] <= merge(e_mem[ridx], wd, be);
            case (AVS_ADDRESS_I)
               `DTR_A_CTRL: begin
                  if (be[0] && wd[0])
                     cfg_active <= 1'b1;
                  if (be[0] && wd[1] && cfg_active && unlk) begin
                     for (i = 0; i < 16; i = i + 1)
                        a_mem[i] <= e_mem[i];
                     cfg_active <= 1'b0;
                     unlocked <= 1'b0;
                  end
                  if (be[0] && wd[2] && q_ok) begin                   // [RL13]
                     quick <= 1'b1;
                     quick_sp <= a_mem[`DTR_R_SPLO];
                  end
                  if (be[0] && wd[3] && unlk)
                     rsim <= 1'b1;
                  if (be[0] && unlk) begin
                     isim <= wd[4];
                     fast_en <= wd[5];
                     fast_free <= wd[6];
                  end
               end
               `DTR_A_PASS:
                  if (unlk && (&AVS_BYTEENABLE_I[2:0])) begin
                     pass <= wd[13:0];
                     lock_en <= AVS_WRITEDATA_I[16];
                  end
               `DTR_A_UNLOCK:
                  unlocked <= ~lock_en | (wd[13:0] == pass)
                              | (wd[13:0] == `DTR_MASTER_CODE);       // [RL14]
               `DTR_A_SIMVAL: simval <= merge(simval, wd, be);
               `DTR_A_SPAN:   if (unlk) span <= merge(span, wd, be);
               `DTR_A_OFFSET: if (unlk) offset <= merge(offset, wd, be);
               `DTR_A_CALCMD:
                  if (be[0] && (wd[0] | wd[1]))
                     offset <= `DTR_OFFSET_RST;                       // [RL20]
               default: ;
            endcase
         end
         if (quick) begin
            if (both)
               test_inv <= ~test_inv;                                 // [RL12]
            else if (up_e & ~KEY_DOWN_I)
               quick_sp <= quick_sp + 16'h0001;
            else if (dn_e & ~KEY_UP_I)
               quick_sp <= quick_sp - 16'h0001;
            if (KEY_OK_I && okc != HOLD_CYC)
               okc <= okc + 28'h0000001;
            if (KEY_OK_I && okc == HOLD_CYC) begin                    // [RL11]
               quick <= 1'b0;
               test_inv <= 1'b0;
            end else if (ok_f) begin
               a_mem[`DTR_R_SPLO] <= quick_sp;
               e_mem[`DTR_R_SPLO] <= quick_sp;
               quick <= 1'b0;
               test_inv <= 1'b0;
            end
         end
         if (!KEY_OK_I || !quick)
            okc <= 28'h0000000;
         if (rsim) begin                                              // [RL18]
            if (up_e)
               sim_rel[0] <= ~sim_rel[0];
            if (dn_e)
               sim_rel[1] <= ~sim_rel[1];
            if (ok_e)
               rsim <= 1'b0;
         end
      end
   end

   // ------------------------
   // timebase, led and backlight
   // ------------------------
   always @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         secc <= 28'h0000000;
         fcnt <= 28'h0000000;
         scnt <= 28'h0000000;
         fast_tog <= 1'b0;
         slow_tog <= 1'b0;
         LED_O <= 1'b0;
         BACKLIGHT_O <= 1'b0;
         RELAY_O <= 2'h0;
      end else begin
         secc <= sec_tick ? 28'h0000000 : secc + 28'h0000001;
         if (fcnt == FAST_HALF - 28'd1) begin
            fcnt <= 28'h0000000;
            fast_tog <= ~fast_tog;
         end else
            fcnt <= fcnt + 28'h0000001;
         if (scnt == SLOW_HALF - 28'd1) begin
            scnt <= 28'h0000000;
            slow_tog <= ~slow_tog;
         end else
            scnt <= scnt + 28'h0000001;
         LED_O <= INTERNAL_FAULT_I | (serr ? slow_tog : fast_tog);   // [RL8]
         BACKLIGHT_O <= (serr | rerr) ? slow_tog : 1'b1;              // [RL19]
         RELAY_O <= rsim ? sim_rel : (con_v ^ {2{quick & test_inv}}); // [RL12]
      end
   end

   // ------------------------
   // relay decision per channel
   // ------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : ch
         wire [15:0] cfg   = a_mem[g * 8 + 0];
         wire [2:0]  func  = cfg[2:0];
         wire [1:0]  eact  = cfg[7:6];
         wire [11:0] don   = a_mem[g * 8 + 4][11:0];
         wire [11:0] doff  = a_mem[g * 8 + 5][11:0];
         wire [31:0] hprod = span * {4'h0, a_mem[g * 8 + 3][11:0]} / `DTR_PERMILLE;
         wire [15:0] h     = cfg[8] ? hprod[15:0] : {4'h0, a_mem[g * 8 + 3][11:0]};
         wire signed [17:0] p  = {{2{pv[15]}}, pv};
         wire signed [17:0] lo = {{2{a_mem[g * 8 + 1][15]}}, a_mem[g * 8 + 1]};
         wire signed [17:0] hi = {{2{a_mem[g * 8 + 2][15]}}, a_mem[g * 8 + 2]};
         wire signed [17:0] hh = {2'b00, h};                          // [RL7]
         wire timed = (func == `DTR_F_SETPOINT) | (func == `DTR_F_WINDOW);
         wire hold  = timed & serr & (eact == `DTR_E_HOLD);
         reg  act;
         reg  run;
         reg  want;
         reg  con;
         reg  [11:0] cnt;
         wire [11:0] dly = act ? doff : don;                          // [RL6]
         always @* begin
            case (func)                                               // [RL1]
               `DTR_F_SETPOINT:
                  if (cfg[3])                                         // [RL5]
                     want = act ? (p >= lo - hh) : (p >= lo);
                  else
                     want = act ? (p <= lo + hh) : (p <= lo);
               `DTR_F_WINDOW:
                  want = act ? (p >= lo - hh && p <= hi + hh)
                             : (p >= lo && p <= hi);                  // [RL2]
               `DTR_F_ERROR: want = serr;                             // [RL3]
               `DTR_F_POWER: want = 1'b1;                             // [RL4]
               default:      want = 1'b0;
            endcase
            if (func == `DTR_F_WINDOW)
               con = act ? cfg[5] : ~cfg[5];                          // [RL17]
            else
               con = act ^ cfg[4];                                    // [RL16]
            if (timed && serr && eact == `DTR_E_OPEN)                 // [RL15]
               con = 1'b0;
            else if (timed && serr && eact == `DTR_E_CLOSE)
               con = 1'b1;
         end
         always @(posedge REF_CLK_I or negedge rst_n) begin
            if (!rst_n) begin
               act <= 1'b0;
               run <= 1'b0;
               cnt <= 12'h000;
            end else if (hold) begin                                  // [RL15]
               run <= 1'b0;
            end else if (!timed) begin
               act <= want;
               run <= 1'b0;
            end else if (want == act) begin
               run <= 1'b0;                                           // [RL21]
            end else if (!run) begin
               if (dly == 12'h000)
                  act <= want;
               else begin
                  run <= 1'b1;                                        // [RL9]
                  cnt <= 12'h000;
               end
            end else if (sec_tick) begin
               if (cnt + 12'h001 >= dly || cnt + 12'h001 >= `DTR_DELAY_MAX) begin
                  act <= want;                                        // [RL6]
                  run <= 1'b0;
               end else
                  cnt <= cnt + 12'h001;
            end
         end
         assign act_v[g] = act;
         assign run_v[g] = run;
         assign con_v[g] = con;
      end
   endgenerate
endmodule

// ===== common/dtr_defs.vh
// constants for the dual trip relay controller
// How it works
// RL1: function per relay: setpoint, window, error, power or off.
// RL2: window: one state inside, the opposite state on both sides.
// RL3: error function: active only during sensor break or short.
// RL4: power function always active; off function never.
// RL5: setpoint direction bit: trip on rising or falling input.
// RL6: separate on and off delays per relay, 0 to 3600 s.
// RL7: hysteresis 0.1 to 25 percent of span or 1 to 2999 counts.
// RL8: led blinks 13 Hz normally, 1 Hz on sensor error, steady on fault.
// RL9: status digit flashes while a delay runs; symbol follows relay.
// RL10: one minute without keys ends configuration, drops edits.
// RL11: quick setpoint: ok held over one second exits unsaved.
// RL12: up and down together in quick setpoint invert the relays.
// RL13: quick setpoint only while both relays use setpoint function.
// RL14: four digit code locks setup; ships unlocked; 2008 always opens.
// RL15: on sensor error a relay does nothing, opens, closes or holds.
// RL16: normally open or closed sense inverts the output.
// RL17: window function: contact closed or open inside the window.
// RL18: relay simulation: arrows toggle relays, no timeout, ok exits.
// RL19: sensor or range error flashes the backlight.
// RL20: rejected calibration or new input type restores factory offset.
// RL21: a delay is cancelled if the trip clears before it ends.
`ifndef DTR_DEFS_VH
`define DTR_DEFS_VH
// ------------------------
// timing
// ------------------------
`define DTR_CLK_HZ        200000000
`define DTR_SEC_S         1
`define DTR_SEC_CYC       (`DTR_SEC_S * `DTR_CLK_HZ)
`define DTR_HOLD_S        1
`define DTR_HOLD_CYC      (`DTR_HOLD_S * `DTR_CLK_HZ)
`define DTR_FAST_HZ       13
`define DTR_FAST_HALF     (`DTR_CLK_HZ / (2 * `DTR_FAST_HZ))
`define DTR_SLOW_HZ       1
`define DTR_SLOW_HALF     (`DTR_CLK_HZ / (2 * `DTR_SLOW_HZ))
`define DTR_TOUT_S        6'd60
`define DTR_DELAY_MAX     12'd3600
`define DTR_PERMILLE      32'd1000
// ------------------------
// register map: byte addresses and relay register indices
// ------------------------
`define DTR_A_CTRL        8'h40
`define DTR_A_PASS        8'h44
`define DTR_A_UNLOCK      8'h48
`define DTR_A_STATUS      8'h4C
`define DTR_A_SIMVAL      8'h50
`define DTR_A_SPAN        8'h54
`define DTR_A_OFFSET      8'h58
`define DTR_A_CALCMD      8'h5C
`define DTR_A_QSP         8'h60
`define DTR_R_CFG         3'h0
`define DTR_R_SPLO        3'h1
`define DTR_R_SPHI        3'h2
`define DTR_R_HYST        3'h3
`define DTR_R_DON         3'h4
`define DTR_R_DOFF        3'h5
// ------------------------
// fields and codes
// ------------------------
`define DTR_F_OFF         3'h0
`define DTR_F_POWER       3'h1
`define DTR_F_ERROR       3'h2
`define DTR_F_WINDOW      3'h3
`define DTR_F_SETPOINT    3'h4
`define DTR_E_NONE        2'h0
`define DTR_E_OPEN        2'h1
`define DTR_E_CLOSE       2'h2
`define DTR_E_HOLD        2'h3
`define DTR_MASTER_CODE   14'h07D8
`define DTR_OFFSET_RST    16'h0000
`define DTR_SPAN_RST      16'h03E8
`endif

// ===== tb/dtr_relay_ctrl_assertions.sv
// port assertions for the relay controller
`timescale 1ns/1ps
module dtr_relay_ctrl_assertions #(
   parameter int FAST_HALF = 4,
   parameter int SLOW_HALF = 10
)(
   input wire logic       REF_CLK_I,
   input wire logic       RST_N_I,
   input wire logic       AVS_READ_I,
   input wire logic       AVS_WRITE_I,
   input wire logic       AVS_WAITREQUEST_O,
   input wire logic       SENSOR_BREAK_FLAG_I,
   input wire logic       SENSOR_SHORT_FLAG_I,
   input wire logic       INPUT_BELOW_RANGE_I,
   input wire logic       INPUT_ABOVE_RANGE_I,
   input wire logic       INTERNAL_FAULT_I,
   input wire logic [1:0] STATUS_FLASH_O,
   input wire logic [1:0] RELAY_SYMBOL_O,
   input wire logic       LED_O,
   input wire logic       BACKLIGHT_O
);
   // ---------------------------------------------
   // run counters
   // ---------------------------------------------
   logic [2:0] up;
   logic       led_q, bl_q;
   logic [7:0] led_run, bl_run, calm, err_run, bad_run;
   wire        sens = SENSOR_BREAK_FLAG_I | SENSOR_SHORT_FLAG_I;
   wire        bad  = sens | INPUT_BELOW_RANGE_I | INPUT_ABOVE_RANGE_I;
   function automatic logic [7:0] inc(input logic [7:0] c);
      return (c == 8'hFF) ? c : c + 8'h01;
   endfunction
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         {up, led_q, bl_q, led_run, bl_run, calm, err_run, bad_run} <= '0;
      end else begin
         up      <= (up == 3'h7) ? up : up + 3'h1;
         led_q   <= LED_O;
         bl_q    <= BACKLIGHT_O;
         led_run <= (LED_O != led_q) ? 8'h00 : inc(led_run);
         bl_run  <= (BACKLIGHT_O != bl_q) ? 8'h00 : inc(bl_run);
         calm    <= (bad | INTERNAL_FAULT_I) ? 8'h00 : inc(calm);
         err_run <= (sens & !INTERNAL_FAULT_I) ? inc(err_run) : 8'h00;
         bad_run <= bad ? inc(bad_run) : 8'h00;
      end
   end
   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   wait_one_a: assert property (
      (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && up == 3'h7 |=> !AVS_WAITREQUEST_O)
      else $error("bus answer late");
   led_steady_a: assert property (
      (INTERNAL_FAULT_I && up == 3'h7) [*4] |-> LED_O)
      else $error("led not steady on fault");
   led_fast_a: assert property (
      calm > 2 * SLOW_HALF |-> led_run < FAST_HALF + 2)
      else $error("led not blinking fast");
   led_slow_a: assert property (
      err_run > 2 * SLOW_HALF |-> led_run < SLOW_HALF + 2)
      else $error("led idle on sensor error");
   led_rate_a: assert property (
      $changed(LED_O) && err_run > 2 * SLOW_HALF |-> led_run >= SLOW_HALF - 2)
      else $error("led too fast on sensor error");
   light_on_a: assert property (
      (!bad && up == 3'h7) [*4] |-> BACKLIGHT_O)
      else $error("backlight off without error");
   light_flash_a: assert property (
      bad_run > 2 * SLOW_HALF |-> bl_run < SLOW_HALF + 2)
      else $error("backlight not flashing on error");
   flash_one_a: assert property (
      STATUS_FLASH_O[0] && $past(STATUS_FLASH_O[0]) |-> $stable(RELAY_SYMBOL_O[0]))
      else $error("relay one moved in delay");
   flash_two_a: assert property (
      STATUS_FLASH_O[1] [*2] |-> $stable(RELAY_SYMBOL_O[1]))
      else $error("relay two moved in delay");
endmodule

// ===== tb/dtr_front_end.sv
// measurement front end model: process value and sensor flags
`timescale 1ns/1ps
module dtr_front_end (
   input  wire logic        clk_i,
   input  wire logic        slow_i,
   input  wire logic [15:0] value_i,
   input  wire logic [3:0]  err_i,
   output logic      [15:0] pv_o,
   output logic      [3:0]  flags_o
);
   // ---------------------------------------------
   // sample and hold, every eighth cycle when slow
   // ---------------------------------------------
   logic [2:0] div = 3'h0;
   initial pv_o = 16'h0000;
   initial flags_o = 4'h0;
   always @(posedge clk_i) begin
      div <= div + 3'h1;
      if (!slow_i || div == 3'h0) begin
         pv_o    <= value_i;
         flags_o <= err_i;
      end
   end
endmodule

// ===== tb/dual_trip_relay_controller_bench.sv
// self-checking bench for the dual trip relay controller
`timescale 1ns/1ps
module dual_trip_relay_controller_bench;
   // ---------------------------------------------
   // stimulus and wiring
   // ---------------------------------------------
   logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic        slow = 1'b0, fault = 1'b0, ku = 1'b0, kd = 1'b0, ko = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, q;
   logic [15:0] pv_cmd = 16'h0000;
   logic [3:0]  err_cmd = 4'h0;
   wire  [31:0] rdat;
   wire  [15:0] pv;
   wire  [3:0]  flg;
   wire  [1:0]  relay, flash, sym;
   wire         wreq;
   int          n_fail = 0, n_tests = 0, cyc = 0;
   dtr_front_end u_fe (.clk_i(clk), .slow_i(slow), .value_i(pv_cmd), .err_i(err_cmd),
      .pv_o(pv), .flags_o(flg));
   dtr_relay_ctrl #(.SEC_CYC(28'h14), .HOLD_CYC(28'h14), .FAST_HALF(28'h4),
      .SLOW_HALF(28'hA)) u_dut (
      .REF_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hF), .AVS_WRITEDATA_I(wdat),
      .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .PV_I(pv),
      .SENSOR_BREAK_FLAG_I(flg[0]), .SENSOR_SHORT_FLAG_I(flg[1]),
      .INPUT_BELOW_RANGE_I(flg[2]), .INPUT_ABOVE_RANGE_I(flg[3]),
      .INTERNAL_FAULT_I(fault), .KEY_UP_I(ku), .KEY_DOWN_I(kd), .KEY_OK_I(ko),
      .RELAY_O(relay), .STATUS_FLASH_O(flash), .RELAY_SYMBOL_O(sym), .LED_O(),
      .BACKLIGHT_O());
   always #2.5 clk = ~clk;
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 40);
      chk({31'h0, wreq}, 32'h0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic cfg(input int r, input logic [31:0] c, lo, hi, don);
      logic [31:0] v [6];
      v = '{c, lo, hi, 32'h000A, don, 32'h0};
      bus(1'b1, 8'h40, 32'h1);
      for (int i = 0; i < 6; i++)
         bus(1'b1, 8'(r * 32 + i * 4), v[i]);
      bus(1'b1, 8'h40, 32'h2);
   endtask
   function automatic logic want(input int f, input int nc, input int e);
      return ((f == 1) || (f == 2 && e == 1)) ^ (nc == 1);
   endfunction
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      int   v;
      logic inw;
      int   k;
      void'($urandom(32'h6e55));
      tick(4);
      rst_n <= 1'b1;
      tick(4);
      bus(1'b1, 8'h7C, 32'h5A5A);
      bus(1'b0, 8'h7C, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h4C, 32'h0);
      chk(q, 32'h40);
      bus(1'b0, 8'h54, 32'h0);
      chk(q, 32'h3E8);
      fault <= 1'b1;
      tick(6);
      fault <= 1'b0;
      for (int f = 0; f < 3; f++)
         for (int nc = 0; nc < 2; nc++)
            for (int e = 0; e < 2; e++) begin
               err_cmd <= (e == 1) ? 4'h1 : 4'h0;
               cfg(0, 32'(f + 16 * nc), 32'h0, 32'h0, 32'h0);
               tick(20);
               chk(relay[0], want(f, nc, e));
            end
      err_cmd <= 4'h4;
      tick(30);
      err_cmd <= 4'h8;
      tick(30);
      err_cmd <= 4'h0;
      slow <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         inw = 1'($urandom_range(0, 1));
         cfg(0, 32'h4 | (32'(p) << 3), 32'h01F4, 32'h0, 32'h0);
         cfg(1, 32'h3 | (32'(inw) << 5), 32'h00C8, 32'h0320, 32'h0);
         for (int i = 0; i < 12; i++) begin
            v = $urandom_range(0, 1000);
            if ((v > 470 && v < 530) || (v > 170 && v < 230) || (v > 770 && v < 830))
               v = 100;
            pv_cmd <= 16'(v);
            tick(20);
            chk(relay[0], (p == 1) ? (v > 500) : (v < 500));
            chk(relay[1], inw ^ !(v > 200 && v < 800));
         end
      end
      slow <= 1'b0;
      bus(1'b1, 8'h40, 32'h24);
      bus(1'b0, 8'h4C, 32'h0);
      chk(q[8], 32'h0);
      pv_cmd <= 16'h02BC;
      for (int a = 1; a < 4; a++) begin
         cfg(0, 32'hC | (32'(a) << 6), 32'h01F4, 32'h0, 32'h0);
         err_cmd <= (a == 2) ? 4'h2 : 4'h1;
         tick(20);
         chk(relay[0], a != 1);
         if (a == 3) begin
            pv_cmd <= 16'h012C;
            tick(20);
            chk(relay[0], 32'h1);
         end
         err_cmd <= 4'h0;
         pv_cmd <= 16'h02BC;
         tick(20);
      end
      bus(1'b1, 8'h40, 32'h1);
      bus(1'b1, 8'h00, 32'h0);
      tick(1300);
      bus(1'b0, 8'h4C, 32'h0);
      chk(q[7], 32'h0);
      bus(1'b1, 8'h40, 32'h2);
      tick(10);
      chk(relay[0], 32'h1);
      pv_cmd <= 16'h012C;
      cfg(0, 32'hC, 32'h01F4, 32'h0, 32'h3);
      cfg(1, 32'hC, 32'h01F4, 32'h0, 32'h3);
      tick(10);
      pv_cmd <= 16'h02BC;
      tick(25);
      chk({flash, relay}, 32'hC);
      pv_cmd <= 16'h012C;
      tick(10);
      chk({flash, relay}, 32'h0);
      pv_cmd <= 16'h02BC;
      k = 0;
      while (relay !== 2'b11 && k < 100) begin
         tick(1);
         k++;
      end
      chk(k >= 35 && k <= 70, 32'h1);
      chk(sym, 32'h3);
      bus(1'b1, 8'h40, 32'h20);
      bus(1'b1, 8'h40, 32'h24);
      bus(1'b0, 8'h4C, 32'h0);
      chk(q[8], 32'h1);
      kd <= 1'b1;
      tick(3);
      ku <= 1'b1;
      tick(3);
      ku <= 1'b0;
      kd <= 1'b0;
      tick(6);
      chk(relay, 32'h0);
      ko <= 1'b1;
      tick(30);
      ko <= 1'b0;
      tick(4);
      bus(1'b0, 8'h4C, 32'h0);
      chk(q[8], 32'h0);
      bus(1'b0, 8'h04, 32'h0);
      chk(q, 32'h01F4);
      for (int c = 1; c < 3; c++) begin
         bus(1'b1, 8'h58, 32'h5);
         bus(1'b1, 8'h5C, 32'(c));
         bus(1'b0, 8'h58, 32'h0);
         chk(q, 32'h0);
      end
      bus(1'b1, 8'h44, 32'h000104D2);
      bus(1'b1, 8'h40, 32'h1);
      bus(1'b1, 8'h40, 32'h2);
      bus(1'b0, 8'h4C, 32'h0);
      chk(q[6], 32'h0);
      bus(1'b1, 8'h58, 32'h9);
      bus(1'b0, 8'h58, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 8'h48, 32'h04D3);
      bus(1'b0, 8'h4C, 32'h0);
      chk(q[6], 32'h0);
      bus(1'b1, 8'h48, 32'h07D8);
      bus(1'b0, 8'h4C, 32'h0);
      chk(q[6], 32'h1);
      conclude();
   end
endmodule
bind dtr_relay_ctrl dtr_relay_ctrl_assertions #(.FAST_HALF(FAST_HALF),
   .SLOW_HALF(SLOW_HALF)) u_chk (.*);
